/* shmf_pkg.sv */
// shared constants for the sync header multiblock framer
// ****************************************************************
// ****************************************************************
`default_nettype none

package shmf_pkg;
  localparam int unsigned BLOCKS_PER_MB  = 32;
  localparam int unsigned MB_PER_EXT     = 1;
  localparam int unsigned DATA_BITS      = 64;
  localparam int unsigned BLOCK_BITS     = 66;
  localparam int unsigned OCTETS_PER_MB  = 256;
  localparam int unsigned CRC_BITS       = 12;
  localparam logic [11:0] CRC_POLY       = 12'h80f;  // x^12+x^11+x^3+x^2+x+1 default
  localparam logic [11:0] CRC_INIT       = 12'h000;
  localparam logic [4:0]  EXT_END_POS    = 5'h16;    // stream bit 22
  localparam int unsigned FIFO_DEPTH     = 8;
  localparam int unsigned SYNC_STAGES    = 3;
  localparam int unsigned DEF_FRAME_OCT  = 8;
endpackage

`default_nettype wire

/* shmf_fifo.sv */
// small synchronous fifo for the incoming scrambled data words
`timescale 1ns/100ps
`default_nettype none

module shmf_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             mclk_i,   // clock
  input  wire logic             rst_i,    // sync reset, high
  input  wire logic [WIDTH-1:0] wdata_i,  // write word
  input  wire logic             wvalid_i, // write offered
  output logic                  wready_o, // not full
  output logic [WIDTH-1:0]      rdata_o,  // head word
  output logic                  rvalid_o, // not empty
  input  wire logic             rready_i  // head consumed
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             full;
  logic             empty;

  assign empty    = (wptr == rptr);
  assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign wready_o = !full;
  assign rvalid_o = !empty;
  assign rdata_o  = mem[rptr[AW-1:0]];

  always_ff @(posedge mclk_i) begin
    if (wvalid_i && !full) begin
      mem[wptr[AW-1:0]] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wptr <= '0;
    end else if (wvalid_i && !full) begin
      wptr <= wptr + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rptr <= '0;
    end else if (rready_i && !empty) begin
      rptr <= rptr + 1'b1;
    end
  end
endmodule

`default_nettype wire

/* shmf_crc12.sv */
// combinational crc-12 update over one 64-bit scrambled block
`timescale 1ns/100ps
`default_nettype none

module shmf_crc12 (
  input  wire logic [11:0] crc_i,  // running parity
  input  wire logic [63:0] data_i, // scrambled block, bit 0 first
  output logic      [11:0] crc_o   // parity after the block
);
  always_comb begin
    logic [11:0] c;
    logic        fb;
    c  = crc_i;
    fb = 1'b0;
    for (int i = 0; i < 64; i++) begin
      fb = c[11] ^ data_i[i];
      c  = {c[10:0], 1'b0};
      if (fb) begin
        c = c ^ shmf_pkg::CRC_POLY;
      end
    end
    crc_o = c;
  end
endmodule

`default_nettype wire

/* shmf_framer.sv */
// transmit framer: multiblock timing, sync header stream and crc-12
`timescale 1ns/100ps
`default_nettype none

module shmf_framer #(
  parameter int unsigned FRAME_OCTETS = shmf_pkg::DEF_FRAME_OCT,
  parameter int unsigned FIFO_DEPTH   = shmf_pkg::FIFO_DEPTH
) (
  input  wire logic        mclk_i,      // clock, 100 MHz
  input  wire logic        rst_i,       // sync reset, high
  input  wire logic        sysref_i,    // sysref pin, asynchronous
  input  wire logic [63:0] data_i,      // scrambled 64-bit block in
  input  wire logic        data_valid_i,// data offered
  output logic             data_ready_o,// fifo has room
  input  wire logic        link_ready_i,// serializer takes a block
  output logic [65:0]      block_o,     // 66-bit block, bit 0 first
  output logic             block_valid_o,// block_o holds a block
  output logic             ext_multiblock_tick_clock_o, // first block of multiblock
  output logic             underrun_o,  // idle block sent, fifo empty
  output logic             frame_fit_o  // frames fit multiblock
);
  // ****************************************************************
  // header stream map
  // ****************************************************************
  function automatic logic stream_bit(input logic [4:0]  idx,
                                      input logic [11:0] crc,
                                      input logic        ext_end);
    logic b;
    b = 1'b0;
    unique case (idx)
      5'h00: b = crc[11];
      5'h01: b = crc[10];
      5'h02: b = crc[9];
      5'h04: b = crc[8];
      5'h05: b = crc[7];
      5'h06: b = crc[6];
      5'h08: b = crc[5];
      5'h09: b = crc[4];
      5'h0a: b = crc[3];
      5'h0c: b = crc[2];
      5'h0d: b = crc[1];
      5'h0e: b = crc[0];
      // fixed ones keep the end pattern unique
      5'h03, 5'h07, 5'h0b, 5'h0f,
      5'h13, 5'h15, 5'h17: b = 1'b1;
      shmf_pkg::EXT_END_POS: b = ext_end;
      // command word and pilot zeros
      5'h10, 5'h11, 5'h12, 5'h14,
      5'h18, 5'h19, 5'h1a: b = 1'b0;
      5'h1b, 5'h1c, 5'h1d, 5'h1e: b = 1'b0;
      5'h1f: b = 1'b1;
    endcase
    return b;
  endfunction

  // ****************************************************************
  // static frame check
  // ****************************************************************
  localparam int unsigned EXT_OCTETS = shmf_pkg::OCTETS_PER_MB * shmf_pkg::MB_PER_EXT;
  localparam logic FIT = ((EXT_OCTETS % FRAME_OCTETS) == 0);
  assign frame_fit_o = FIT;

  // ****************************************************************
  // input fifo
  // ****************************************************************
  logic [63:0] head;
  logic        head_valid;
  logic        take;

  assign take = link_ready_i;

  shmf_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH)
  ) i_shmf_fifo (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .wdata_i  (data_i),
    .wvalid_i (data_valid_i),
    .wready_o (data_ready_o),
    .rdata_o  (head),
    .rvalid_o (head_valid),
    .rready_i (take)
  );

  // ****************************************************************
  // sysref capture
  // ****************************************************************
  logic [2:0] sysref_sync;
  logic       sysref_level;
  logic       sysref_rise;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sysref_sync <= 3'h0;
    end else begin
      sysref_sync <= {sysref_sync[1:0], sysref_i};
    end
  end

  // a change counts only when stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sysref_level <= 1'b0;
    end else if (sysref_sync[1] == sysref_sync[2]) begin
      sysref_level <= sysref_sync[2];
    end
  end

  assign sysref_rise = (sysref_sync[1] == sysref_sync[2]) && sysref_sync[2] && !sysref_level;

  // ****************************************************************
  // local multiblock clock
  // ****************************************************************
  logic [4:0] blk_cnt;
  logic [0:0] mb_cnt;
  logic       last_mb;

  // counts blocks actually handed to the serializer, so one wrap is
  // 66*32 line bits; sysref forces the next block to be block 0
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      blk_cnt <= 5'h00;
    end else if (sysref_rise) begin
      blk_cnt <= 5'h00;
    end else if (take) begin
      blk_cnt <= blk_cnt + 5'h01;
    end
  end

  // with one multiblock per extended multiblock this never leaves 0
  always_ff @(posedge mclk_i) begin
    if (rst_i || sysref_rise) begin
      mb_cnt <= 1'b0;
    end else if (take && blk_cnt == 5'h1f) begin
      mb_cnt <= (mb_cnt == 1'(shmf_pkg::MB_PER_EXT - 1)) ? 1'b0 : mb_cnt + 1'b1;
    end
  end

  assign last_mb = (mb_cnt == 1'(shmf_pkg::MB_PER_EXT - 1));

  // ****************************************************************
  // crc accumulation
  // ****************************************************************
  logic [63:0] blk_data;
  logic [11:0] crc_acc;
  logic [11:0] crc_seed;
  logic [11:0] next_crc;
  logic [11:0] crc_sent;

  // an empty fifo sends an all-zero idle block rather than stalling
  assign blk_data = head_valid ? head : 64'h0;
  assign crc_seed = (blk_cnt == 5'h00) ? shmf_pkg::CRC_INIT : crc_acc;

  shmf_crc12 i_shmf_crc12 (
    .crc_i  (crc_seed),
    .data_i (blk_data),
    .crc_o  (next_crc)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i || sysref_rise) begin
      crc_acc <= shmf_pkg::CRC_INIT;
    end else if (take) begin
      crc_acc <= next_crc;
    end
  end

  // parity of the finished multiblock goes out in the next one
  always_ff @(posedge mclk_i) begin
    if (rst_i || sysref_rise) begin
      crc_sent <= shmf_pkg::CRC_INIT;
    end else if (take && blk_cnt == 5'h1f) begin
      crc_sent <= next_crc;
    end
  end

  // ****************************************************************
  // block output
  // ****************************************************************
  logic hdr_bit;

  // block 31 reads crc_sent before it updates, so parity lags one mb
  assign hdr_bit = stream_bit(blk_cnt, crc_sent, last_mb);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      block_o <= {64'h0, 2'h2};
    end else if (take) begin
      block_o <= {blk_data, hdr_bit, ~hdr_bit};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      block_valid_o <= 1'b0;
    end else begin
      block_valid_o <= take;
    end
  end

  // the tick rides with block 0, so it shifts with every sysref cut
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ext_multiblock_tick_clock_o <= 1'b0;
    end else begin
      ext_multiblock_tick_clock_o <= take && (blk_cnt == 5'h00);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      underrun_o <= 1'b0;
    end else begin
      underrun_o <= take && !head_valid;
    end
  end
endmodule

`default_nettype wire

/* shmf_props.sv */
// checker: sync header stream layout and multiblock timing at the framer ports
`timescale 1ns/100ps
`default_nettype none
module shmf_props #(
  parameter int unsigned FRAME_OCTETS = 8
) (
  input wire logic        mclk_i,                      // clock
  input wire logic        rst_i,                       // sync reset, high
  input wire logic        link_ready_i,                // serializer takes a block
  input wire logic [65:0] block_o,                     // block out
  input wire logic        block_valid_o,               // block present
  input wire logic        ext_multiblock_tick_clock_o, // first block of multiblock
  input wire logic        underrun_o,                  // idle block sent
  input wire logic        frame_fit_o                  // frames fit
);
  localparam logic [31:0] ONES = 32'h80a88888;
  localparam logic [31:0] ZERO = 32'h7f170000;
  logic [5:0] cnt;
  logic [4:0] hist;
  wire logic  hb = block_o[1];
  wire logic  tk = ext_multiblock_tick_clock_o;
  wire logic  in_mb = block_valid_o && !tk && !cnt[5];
  // cnt is the stream index of each non-tick block on block_o (on the tick it holds the length just ended); a sysref cut restarts it at the tick
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt <= 6'h0;
      hist <= 5'h0;
    end else if (block_valid_o) begin
      cnt <= tk ? 6'h1 : cnt + 6'h1;
      hist <= {hist[3:0], hb};
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  hdr_pair_a: assert property (block_valid_o |-> block_o[0] != block_o[1])
    else $error("sync header bits equal");
  take_block_a: assert property (1 |=> block_valid_o == $past(link_ready_i))
    else $error("block output does not follow take");
  mb_length_a: assert property (block_valid_o && cnt == 6'h20 |-> tk)
    else $error("multiblock not 32 blocks");
  end_pilot_a: assert property (tk && cnt == 6'h20 |-> hist == 5'h01)
    else $error("stream does not end in end pilot");
  fixed_ones_a: assert property (in_mb && ONES[cnt[4:0]] |-> hb)
    else $error("fixed one missing");
  cmd_zero_a: assert property (in_mb && ZERO[cnt[4:0]] |-> !hb)
    else $error("command bit not zero");
  ext_end_a: assert property (in_mb && cnt == 6'h16 |-> hb)
    else $error("extended end flag clear");
  tick_valid_a: assert property (tk |-> block_valid_o)
    else $error("tick without a block");
  idle_fill_a: assert property (underrun_o |-> block_valid_o && block_o[65:2] == 64'h0)
    else $error("idle block not zero");
  fit_flag_a: assert property (frame_fit_o == ((256 % FRAME_OCTETS) == 0))
    else $error("frame fit flag wrong");
endmodule
bind shmf_framer shmf_props #(.FRAME_OCTETS(FRAME_OCTETS)) i_shmf_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .link_ready_i(link_ready_i), .block_o(block_o),
  .block_valid_o(block_valid_o), .ext_multiblock_tick_clock_o(ext_multiblock_tick_clock_o),
  .underrun_o(underrun_o), .frame_fit_o(frame_fit_o));
`default_nettype wire

/* shmf_link_rx.sv */
// link receiver model: paces blocks, checks headers, and crc-12 of each clean full-length multiblock followed by another full-length one
`timescale 1ns/100ps
`default_nettype none
module shmf_link_rx (
  input  wire logic        mclk_i,       // clock
  input  wire logic        rst_i,        // sync reset, high
  input  wire logic [1:0]  pace_i,       // 0 prompt, 1 slow, 2 stopped
  input  wire logic [65:0] block_i,      // block from the framer
  input  wire logic        valid_i,      // block present
  input  wire logic        tick_i,       // first block of multiblock
  output logic             link_ready_o, // takes a block
  output int               checked_o,    // multiblocks checked
  output int               bad_o         // header or parity faults
);
  logic [31:0] hdr_stream;
  logic [11:0] run, prev, got;
  logic [5:0]  idx;
  logic        havep;
  logic        pilot_bad;
  function automatic logic [11:0] crc_upd(logic [11:0] c, logic [63:0] d);
    for (int i = 0; i < 64; i++) begin
      c = c[11] ^ d[i] ? {c[10:0], 1'b0} ^ shmf_pkg::CRC_POLY : {c[10:0], 1'b0};
    end
    return c;
  endfunction
  // places where the end pattern 00001 closes, bit 0 sent first
  function automatic int pilot_hits(logic [31:0] s);
    int k;
    k = 0;
    for (int p = 4; p < 32; p++) k += int'(s[p -: 5] == 5'h10);
    return k;
  endfunction
  assign got = {hdr_stream[0], hdr_stream[1], hdr_stream[2], hdr_stream[4], hdr_stream[5],
                hdr_stream[6], hdr_stream[8], hdr_stream[9], hdr_stream[10],
                hdr_stream[12], hdr_stream[13], hdr_stream[14]};
  // crc mode: the pattern must close at bit 31 and nowhere else
  assign pilot_bad = pilot_hits(hdr_stream) != 1 || hdr_stream[31:27] != 5'h10;
  // a cut multiblock after sysref is never compared, its parity is meaningless
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      link_ready_o <= 1'b0;
      idx <= 6'h0;
      havep <= 1'b0;
      checked_o <= 0;
      bad_o <= 0;
    end else begin
      link_ready_o <= pace_i == 2'h0 || (pace_i == 2'h1 && !link_ready_o);
      if (valid_i) begin
        // a run of header faults would call for sysref and a fresh search
        bad_o <= bad_o + int'(block_i[0] == block_i[1])
                 + int'(tick_i && havep && idx == 6'h20 && got != prev)
                 + int'(tick_i && idx == 6'h20 && pilot_bad);
        if (tick_i) begin
          checked_o <= checked_o + int'(havep && idx == 6'h20);
          // one clean pilot aligns in crc mode; fec would need several
          havep <= idx == 6'h20 && !pilot_bad;
          prev <= run;
          run <= crc_upd(shmf_pkg::CRC_INIT, block_i[65:2]);
          hdr_stream[0] <= block_i[1];
          idx <= 6'h1;
        end else begin
          run <= crc_upd(run, block_i[65:2]);
          if (!idx[5]) hdr_stream[idx[4:0]] <= block_i[1];
          idx <= idx + 6'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* shmf_framer_tb.sv */
// self-checking bench for the sync header multiblock framer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module shmf_framer_tb;
  logic        mclk_i = 0, rst_i = 1, sysref_i = 0, data_valid_i = 0;
  logic [63:0] data_i = 64'h0;
  logic [1:0]  pace = 2'h0;
  logic        link_ready_i, data_ready_o, block_valid_o, tick, underrun_o, frame_fit_o;
  logic [65:0] block_o;
  logic [63:0] q[$];
  int          err_total = 0, tests_run = 0, cyc = 0, checked, bad, n, c0;
  shmf_framer i_shmf_framer (.mclk_i(mclk_i), .rst_i(rst_i), .sysref_i(sysref_i),
    .data_i(data_i), .data_valid_i(data_valid_i), .data_ready_o(data_ready_o),
    .link_ready_i(link_ready_i), .block_o(block_o), .block_valid_o(block_valid_o),
    .ext_multiblock_tick_clock_o(tick), .underrun_o(underrun_o), .frame_fit_o(frame_fit_o));
  shmf_link_rx i_shmf_link_rx (.mclk_i(mclk_i), .rst_i(rst_i), .pace_i(pace),
    .block_i(block_o), .valid_i(block_valid_o), .tick_i(tick),
    .link_ready_o(link_ready_i), .checked_o(checked), .bad_o(bad));
  initial forever #5 mclk_i = ~mclk_i;
  // ****************************************************************
  // helpers
  // ****************************************************************
  always @(negedge mclk_i) if (block_valid_o) q.push_back(block_o[65:2]);
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop;
    end
  end
  task report_and_stop;
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task push(input logic [63:0] w);
    @(negedge mclk_i);
    data_i = w;
    data_valid_i = 1'b1;
    while (!data_ready_o) @(negedge mclk_i);
  endtask
  task wait_tick;
    do @(negedge mclk_i); while (tick !== 1'b1);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    repeat (3) @(negedge mclk_i);
    `CHK("reset block", 66'h2, block_o)
    `CHK("reset valid", 1'b0, block_valid_o)
    `CHK("frame fit", 1'b1, frame_fit_o)
    rst_i = 1'b0;
  endtask
  task t_fifo;
    pace = 2'h2;
    repeat (3) @(negedge mclk_i);
    for (int i = 0; i < 8; i++) push(64'h0123456789abcdef ^ 64'(i));
    @(negedge mclk_i);
    data_i = 64'h0123456789abcdef ^ 64'h8;
    `CHK("full refuses", 1'b0, data_ready_o)
    q.delete();
    pace = 2'h0;
    while (!data_ready_o) @(negedge mclk_i);
    @(negedge mclk_i);
    data_valid_i = 1'b0;
    repeat (12) @(negedge mclk_i);
    for (int i = 0; i < 9; i++) `CHK("fifo order", 64'h0123456789abcdef ^ 64'(i), q[i])
    `CHK("idle fill", 1'b1, underrun_o)
  endtask
  task t_sysref;
    wait_tick;
    repeat (10) @(negedge mclk_i);
    sysref_i = 1'b1; // a single pulse, never a continuous one
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (!tick && n < 20);
    // three sync flops, one edge to clear the counter, one to launch the tick
    `CHK("sysref realign", shmf_pkg::SYNC_STAGES + 2, n)
    sysref_i = 1'b0;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (!tick && n < 40);
    `CHK("tick spacing", 32, n)
  endtask
  task t_stream;
    c0 = checked;
    pace = 2'h1;
    for (int i = 0; i < 100; i++) begin
      if (i == 50) pace = 2'h0;
      push({2{32'(i) * 32'h9e3779b9}});
    end
    @(negedge mclk_i);
    data_valid_i = 1'b0;
    repeat (80) @(negedge mclk_i);
    `CHK("parity checked", 1'b1, checked - c0 >= 3)
    `CHK("link faults", 0, bad)
  endtask
  initial begin
    t_reset;
    t_fifo;
    t_sysref;
    t_stream;
    report_and_stop;
  end
endmodule
`default_nettype wire
